/* File: design/adm_pkg.sv */
// Shared constants, types and functions of the audio DAC mode control block
package adm_pkg;

    // Control word layout
    localparam int CW_BITS = 16;
    localparam int SEL_LO = 9;
    localparam int SEL_HI = 10;
    localparam logic [1:0] SEL_RIGHT_GAIN = 2'h1;
    localparam logic [1:0] SEL_PLAYBACK = 2'h2;
    localparam logic [1:0] SEL_FORMAT = 2'h3;

    // Right attenuation register fields
    localparam int GAIN_CODE_LO = 0;
    localparam int GAIN_COMMIT_BIT = 8;
    localparam logic [7:0] GAIN_MUTE = 8'h00;
    localparam logic [7:0] GAIN_UNITY = 8'hFF;
    localparam logic [7:0] RIGHT_GAIN_RESET = 8'hFF;

    // Playback control register fields
    localparam int PB_MUTE_BIT = 0;
    localparam int PB_DEEMPH_BIT = 1;
    localparam int PB_FORCE_BIT = 2;
    localparam int PB_WLEN_LO = 3;
    localparam int PB_LROUTE_LO = 5;
    localparam int PB_RROUTE_LO = 7;
    localparam logic [8:0] PB_RESET = 9'h120;

    // Format and clock register fields
    localparam int FC_I2S_BIT = 0;
    localparam int FC_POL_BIT = 1;
    localparam int FC_COMMON_BIT = 2;
    localparam int FC_SYSCLK_BIT = 3;
    localparam int FC_RATE_MUL_LO = 4;
    localparam int FC_FAMILY_LO = 6;
    localparam int FC_ZDET_BIT = 8;
    localparam logic [8:0] FC_RESET = 9'h000;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int ZERO_RUN_DEFAULT = 65536;
    localparam int RAMP_STEP_NS = 1000;
    localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SRC_MUTE,
        SRC_RIGHT,
        SRC_LEFT,
        SRC_AVG
    } adm_src_e;

    // Gain of code over 255, rounded
    function automatic logic [7:0] adm_scale(input logic [7:0] a,
                                             input logic [7:0] b);
        logic [15:0] prod;
        prod = 16'(a) * 16'(b) + 16'h007F;
        return 8'(prod / 16'h00FF);
    endfunction

    // Two routing bits, first bit is the high one
    function automatic adm_src_e adm_route(input logic first,
                                           input logic second);
        return adm_src_e'({first, second});
    endfunction

endpackage

/* File: design/adm_word_if.sv */
// Carrier of latched control words between receiver and register bank
`timescale 1ns/1ps
`default_nettype none
interface adm_word_if;
    logic [15:0] word;
    logic valid;
    modport rx (output word, output valid);
    modport bank (input word, input valid);
endinterface
`default_nettype wire

/* File: design/adm_serial_rx.sv */
// Three-wire control port receiver: shifts 16 bits, hands over on latch
`timescale 1ns/1ps
`default_nettype none
module adm_serial_rx
    import adm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ctrl_bit_clock,
    input wire logic ctrl_serial_data,
    input wire logic ctrl_latch,
    adm_word_if.rx wr
);
    logic [1:0] clk_s_r;
    logic [1:0] dat_s_r;
    logic [1:0] lat_s_r;
    logic clk_d_r;
    logic lat_d_r;
    logic [15:0] shift_r, shift_nxt;
    logic [15:0] word_r, word_nxt;
    logic valid_r, valid_nxt;

    always_ff @(posedge ref_clk) begin
        clk_s_r <= {clk_s_r[0], ctrl_bit_clock};
        dat_s_r <= {dat_s_r[0], ctrl_serial_data};
        lat_s_r <= {lat_s_r[0], ctrl_latch};
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        shift_nxt = shift_r;
        word_nxt = word_r;
        valid_nxt = 1'b0;
        if (clk_s_r[1] && !clk_d_r) begin
            shift_nxt = {shift_r[14:0], dat_s_r[1]};
        end
        if (lat_s_r[1] && !lat_d_r) begin
            word_nxt = shift_r;
            valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clk_d_r <= 1'b0;
            lat_d_r <= 1'b0;
            shift_r <= 16'h0000;
            word_r <= 16'h0000;
            valid_r <= 1'b0;
        end else begin
            clk_d_r <= clk_s_r[1];
            lat_d_r <= lat_s_r[1];
            shift_r <= shift_nxt;
            word_r <= word_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign wr.word = word_r;
    assign wr.valid = valid_r;

    latch_pulse_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        valid_r |=> !valid_r)
        else $error("Latch handover lasted more than one cycle");
endmodule
`default_nettype wire

/* File: design/adm_zero_detect.sv */
// Counts bit clock cycles of continuous zero audio input
`timescale 1ns/1ps
`default_nettype none
module adm_zero_detect
    import adm_pkg::*;
#(
    parameter int ZERO_RUN = ZERO_RUN_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic audio_bit_clock,
    input wire logic audio_serial_data,
    output logic zero_found
);
    localparam int CW = $clog2(ZERO_RUN + 1);
    localparam logic [CW-1:0] RUN_END = CW'(ZERO_RUN);

    logic [1:0] bck_s_r;
    logic [1:0] dat_s_r;
    logic bck_d_r;
    logic [CW-1:0] run_r, run_nxt;
    logic found_r, found_nxt;

    always_ff @(posedge ref_clk) begin
        bck_s_r <= {bck_s_r[0], audio_bit_clock};
        dat_s_r <= {dat_s_r[0], audio_serial_data};
    end

    always_comb begin
        run_nxt = run_r;
        if (bck_s_r[1] && !bck_d_r) begin
            if (dat_s_r[1]) begin
                run_nxt = '0;
            end else if (run_r != RUN_END) begin
                run_nxt = run_r + CW'(1);
            end
        end
        found_nxt = (run_nxt == RUN_END);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bck_d_r <= 1'b0;
            run_r <= '0;
            found_r <= 1'b0;
        end else begin
            bck_d_r <= bck_s_r[1];
            run_r <= run_nxt;
            found_r <= found_nxt;
        end
    end

    assign zero_found = found_r;
endmodule
`default_nettype wire

/* File: design/adm_control.sv */
// Program register bank and mode control of the stereo audio DAC
`timescale 1ns/1ps
`default_nettype none
module adm_control
    import adm_pkg::*;
#(
    parameter int ZERO_RUN_CYCLES = ZERO_RUN_DEFAULT,
    parameter int RAMP_CYCLES = RAMP_STEP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic reset_pin_n,
    input wire logic ctrl_bit_clock,
    input wire logic ctrl_serial_data,
    input wire logic ctrl_latch,
    input wire logic audio_bit_clock,
    input wire logic audio_word_clock,
    input wire logic audio_serial_data,
    input wire logic [7:0] left_gain_code,
    output logic [7:0] right_gain_code,
    output logic [7:0] left_gain_level,
    output logic [7:0] right_gain_level,
    output logic soft_mute_active,
    output logic deemph_enable,
    output logic [1:0] word_length_sel,
    output adm_src_e left_route,
    output adm_src_e right_route,
    output logic serial_format_i2s,
    output logic word_clock_polarity,
    output logic left_channel_phase,
    output logic common_gain_sel,
    output logic sysclk_ratio_sel,
    output logic [1:0] rate_multiple_sel,
    output logic [1:0] rate_family_sel,
    output logic zero_detect_enable,
    output logic zero_input_found,
    output logic midscale_output,
    output logic modulator_connect
);
    localparam int RCW = $clog2(RAMP_CYCLES + 1);
    localparam logic [RCW-1:0] RAMP_LAST = RCW'(RAMP_CYCLES - 1);

    adm_word_if wif ();

    logic [1:0] pin_s_r;
    logic [1:0] wck_s_r;
    logic pin_run;
    logic zero_found;

    logic [7:0] gain_store_r, gain_store_nxt;
    logic [7:0] gain_act_r, gain_act_nxt;
    logic [8:0] pb_r, pb_nxt;
    logic [8:0] fc_r, fc_nxt;
    logic [7:0] ramp_r, ramp_nxt;
    logic [RCW-1:0] tick_r, tick_nxt;
    logic [7:0] lvl_l_r, lvl_l_nxt;
    logic [7:0] lvl_r_r, lvl_r_nxt;
    logic [7:0] right_sel_code;
    logic mid_r, mid_nxt;
    logic phase_r, phase_nxt;
    logic [1:0] sel;

    ////////////////////////////////////////////////////////////////////
    adm_serial_rx u_rx (
        .ref_clk(ref_clk),
        .srst(srst),
        .ctrl_bit_clock(ctrl_bit_clock),
        .ctrl_serial_data(ctrl_serial_data),
        .ctrl_latch(ctrl_latch),
        .wr(wif.rx)
    );

    adm_zero_detect #(
        .ZERO_RUN(ZERO_RUN_CYCLES)
    ) u_zero (
        .ref_clk(ref_clk),
        .srst(srst),
        .audio_bit_clock(audio_bit_clock),
        .audio_serial_data(audio_serial_data),
        .zero_found(zero_found)
    );

    always_ff @(posedge ref_clk) begin
        pin_s_r <= {pin_s_r[0], reset_pin_n};
        wck_s_r <= {wck_s_r[0], audio_word_clock};
    end

    assign pin_run = pin_s_r[1];
    assign sel = wif.word[SEL_HI:SEL_LO];

    ////////////////////////////////////////////////////////////////////
    // Register bank
    always_comb begin
        gain_store_nxt = gain_store_r;
        gain_act_nxt = gain_act_r;
        pb_nxt = pb_r;
        fc_nxt = fc_r;
        if (!pin_run) begin
            gain_store_nxt = RIGHT_GAIN_RESET;
            gain_act_nxt = RIGHT_GAIN_RESET;
            pb_nxt = PB_RESET;
            fc_nxt = FC_RESET;
        end else if (wif.valid) begin
            if (sel == SEL_RIGHT_GAIN) begin
                gain_store_nxt = wif.word[GAIN_CODE_LO +: 8];
                if (wif.word[GAIN_COMMIT_BIT]) begin
                    gain_act_nxt = wif.word[GAIN_CODE_LO +: 8];
                end
            end else if (sel == SEL_PLAYBACK) begin
                pb_nxt = wif.word[8:0];
            end else if (sel == SEL_FORMAT) begin
                fc_nxt = wif.word[8:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gain_store_r <= RIGHT_GAIN_RESET;
            gain_act_r <= RIGHT_GAIN_RESET;
            pb_r <= PB_RESET;
            fc_r <= FC_RESET;
        end else begin
            gain_store_r <= gain_store_nxt;
            gain_act_r <= gain_act_nxt;
            pb_r <= pb_nxt;
            fc_r <= fc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Soft mute ramp and gain levels
    always_comb begin
        ramp_nxt = ramp_r;
        tick_nxt = tick_r;
        if (tick_r == RAMP_LAST) begin
            tick_nxt = '0;
            if (pb_r[PB_MUTE_BIT] && ramp_r != GAIN_MUTE) begin
                ramp_nxt = ramp_r - 8'h01;
            end else if (!pb_r[PB_MUTE_BIT] && ramp_r != GAIN_UNITY) begin
                ramp_nxt = ramp_r + 8'h01;
            end
        end else begin
            tick_nxt = tick_r + RCW'(1);
        end
        right_sel_code = fc_r[FC_COMMON_BIT] ? left_gain_code : gain_act_r;
        lvl_l_nxt = adm_scale(left_gain_code, ramp_r);
        lvl_r_nxt = adm_scale(right_sel_code, ramp_r);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ramp_r <= GAIN_UNITY;
            tick_r <= '0;
            lvl_l_r <= GAIN_UNITY;
            lvl_r_r <= GAIN_UNITY;
        end else begin
            ramp_r <= ramp_nxt;
            tick_r <= tick_nxt;
            lvl_l_r <= lvl_l_nxt;
            lvl_r_r <= lvl_r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output state
    always_comb begin
        mid_nxt = !pin_run || pb_r[PB_FORCE_BIT]
                  || (fc_r[FC_ZDET_BIT] && zero_found);
        // high phase is left unless swapped
        phase_nxt = wck_s_r[1] ^ fc_r[FC_POL_BIT];
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mid_r <= 1'b1;
            phase_r <= 1'b0;
        end else begin
            mid_r <= mid_nxt;
            phase_r <= phase_nxt;
        end
    end

    assign right_gain_code = gain_act_r;
    assign left_gain_level = lvl_l_r;
    assign right_gain_level = lvl_r_r;
    assign soft_mute_active = pb_r[PB_MUTE_BIT];
    assign deemph_enable = pb_r[PB_DEEMPH_BIT];
    assign word_length_sel = pb_r[PB_WLEN_LO +: 2];
    assign left_route = adm_route(pb_r[PB_LROUTE_LO], pb_r[PB_LROUTE_LO+1]);
    assign right_route = adm_route(pb_r[PB_RROUTE_LO], pb_r[PB_RROUTE_LO+1]);
    assign serial_format_i2s = fc_r[FC_I2S_BIT];
    assign word_clock_polarity = fc_r[FC_POL_BIT];
    assign left_channel_phase = phase_r;
    assign common_gain_sel = fc_r[FC_COMMON_BIT];
    assign sysclk_ratio_sel = fc_r[FC_SYSCLK_BIT];
    assign rate_multiple_sel = fc_r[FC_RATE_MUL_LO +: 2];
    assign rate_family_sel = fc_r[FC_FAMILY_LO +: 2];
    assign zero_detect_enable = fc_r[FC_ZDET_BIT];
    assign zero_input_found = zero_found;
    assign midscale_output = mid_r;
    assign modulator_connect = !mid_r;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    sel_decode_a: assert property (
        pin_run && wif.valid && sel == SEL_FORMAT
        |=> fc_r == $past(wif.word[8:0]) && $stable(pb_r))
        else $error("Format word not routed by select field");

    latch_only_a: assert property (
        pin_run && !wif.valid
        |=> $stable(pb_r) && $stable(fc_r) && $stable(gain_store_r))
        else $error("Register changed without latch");

    gain_hold_a: assert property (
        pin_run && wif.valid && sel == SEL_RIGHT_GAIN
        && !wif.word[GAIN_COMMIT_BIT]
        |=> $stable(gain_act_r) && gain_store_r == $past(wif.word[7:0]))
        else $error("Uncommitted code took effect");

    gain_load_a: assert property (
        pin_run && wif.valid && sel == SEL_RIGHT_GAIN
        && wif.word[GAIN_COMMIT_BIT]
        |=> right_gain_code == $past(wif.word[7:0]))
        else $error("Committed code not active");

    gain_scale_a: assert property (
        ramp_r == GAIN_UNITY && !fc_r[FC_COMMON_BIT]
        && !$changed(gain_act_r)
        |=> right_gain_level == $past(gain_act_r))
        else $error("Unity ramp does not pass code through");

    soft_ramp_a: assert property (
        pb_r[PB_MUTE_BIT] && $past(pb_r[PB_MUTE_BIT])
        |-> ramp_r == $past(ramp_r) || ramp_r == $past(ramp_r) - 8'h01)
        else $error("Mute ramp stepped abruptly");

    force_zero_a: assert property (
        pb_r[PB_FORCE_BIT] |=> midscale_output && !modulator_connect)
        else $error("Force bit did not hold midscale");

    pin_reset_a: assert property (
        !pin_run |=> midscale_output && pb_r == PB_RESET && fc_r == FC_RESET)
        else $error("Reset pin did not force midscale and defaults");

    zero_mute_a: assert property (
        fc_r[FC_ZDET_BIT] && zero_found |=> midscale_output)
        else $error("Zero run did not force midscale");

    zero_off_a: assert property (
        pin_run && !fc_r[FC_ZDET_BIT] && !pb_r[PB_FORCE_BIT]
        |=> modulator_connect)
        else $error("Output disconnected with detection off");
endmodule
`default_nettype wire

/* File: sim/adm_host_model.sv */
// Host controller model driving the three-wire control port
`timescale 1ns/1ps
`default_nettype none
module adm_host_model (
    output var logic ctrl_bit_clock,
    output var logic ctrl_serial_data,
    output var logic ctrl_latch
);
    initial begin
        ctrl_bit_clock = 1'b0;
        ctrl_serial_data = 1'b0;
        ctrl_latch = 1'b0;
    end

    // Sixteen bits MSB first, then latch
    // Select field travels in bits 10:9
    task automatic send(input logic [15:0] w, input bit do_latch);
        for (int i = 15; i >= 0; i--) begin
            ctrl_serial_data = w[i];
            #80 ctrl_bit_clock = 1'b1;
            #80 ctrl_bit_clock = 1'b0;
        end
        if (do_latch) begin
            #80 ctrl_latch = 1'b1;
            #80 ctrl_latch = 1'b0;
        end
        // Released line shows the inverse of the last bit
        #80 ctrl_serial_data = ~w[0];
    endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench of the audio DAC mode control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adm_pkg::*;
    typedef struct {string name; int sel; logic [31:0] exp;} adm_note_s;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic abclk = 1'b0;
    logic awclk = 1'b0;
    logic adata = 1'b1;
    logic [7:0] lcode = 8'hFF;
    wire logic cbclk;
    wire logic cdata;
    wire logic clatch;
    logic [7:0] rcode, llev, rlev;
    logic smute, deemph, i2s, pol, phase, common, sysclk, zdet, zfound;
    logic mid, modc;
    logic [1:0] wlen, rmul, fam;
    adm_src_e lroute, rroute;
    logic [7:0] m_rc;
    logic [8:0] m_pb, m_fc;
    adm_note_s notes[$];
    event chk_ev;
    int errors = 0;
    int compares = 0;
    int cyc = 0;

    initial forever #10 ref_clk = ~ref_clk;
    initial begin
        #32;
        forever #80 abclk = ~abclk;
    end

    adm_host_model host_u (.ctrl_bit_clock(cbclk),
        .ctrl_serial_data(cdata), .ctrl_latch(clatch));

    adm_control #(.ZERO_RUN_CYCLES(16), .RAMP_CYCLES(2)) dut_u (
        .ref_clk(ref_clk), .srst(srst), .reset_pin_n(reset_pin_n),
        .ctrl_bit_clock(cbclk), .ctrl_serial_data(cdata),
        .ctrl_latch(clatch), .audio_bit_clock(abclk),
        .audio_word_clock(awclk), .audio_serial_data(adata),
        .left_gain_code(lcode), .right_gain_code(rcode),
        .left_gain_level(llev), .right_gain_level(rlev),
        .soft_mute_active(smute), .deemph_enable(deemph),
        .word_length_sel(wlen), .left_route(lroute),
        .right_route(rroute), .serial_format_i2s(i2s),
        .word_clock_polarity(pol), .left_channel_phase(phase),
        .common_gain_sel(common), .sysclk_ratio_sel(sysclk),
        .rate_multiple_sel(rmul), .rate_family_sel(fam),
        .zero_detect_enable(zdet), .zero_input_found(zfound),
        .midscale_output(mid), .modulator_connect(modc));

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] obs(input int sel);
        case (sel)
            0: return {7'h00, rcode, smute, deemph, wlen, 2'(lroute),
                2'(rroute), i2s, pol, common, sysclk, rmul, fam, zdet};
            1: return {29'h0, mid, modc, zfound};
            2: return {24'h0, llev};
            3: return {24'h0, rlev};
            4: return {31'h0, phase};
            default: return {31'h0, (llev !== 8'h00) && (llev !== 8'hFF)};
        endcase
    endfunction

    function automatic logic [31:0] exp_snap();
        return {7'h00, m_rc, m_pb[0], m_pb[1], m_pb[4:3], m_pb[5], m_pb[6],
            m_pb[7], m_pb[8], m_fc[0], m_fc[1], m_fc[2], m_fc[3],
            m_fc[5:4], m_fc[7:6], m_fc[8]};
    endfunction

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Every queued note is compared, oldest first, when a result is announced
    always begin
        adm_note_s n;
        @(chk_ev);
        while (notes.size() > 0) begin
            n = notes.pop_front();
            check(n.name, obs(n.sel), n.exp);
        end
    end

    task automatic note(string name, int sel, logic [31:0] exp);
        notes.push_back('{name, sel, exp});
        ->chk_ev;
    endtask

    task automatic settle(int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task automatic model_defaults();
        m_rc = RIGHT_GAIN_RESET;
        m_pb = PB_RESET;
        m_fc = FC_RESET;
    endtask

    task automatic wr(logic [1:0] sel, logic [8:0] d, bit latch);
        host_u.send({5'($urandom), sel, d}, latch);
        if (latch && reset_pin_n) begin
            case (sel)
                SEL_RIGHT_GAIN: if (d[GAIN_COMMIT_BIT]) m_rc = d[7:0];
                SEL_PLAYBACK: m_pb = d;
                SEL_FORMAT: m_fc = d;
                default: ;
            endcase
        end
        settle(10);
        note("registers", 0, exp_snap());
    endtask

    // Format writes spaced beyond 20 us
    task automatic fmt(logic [8:0] d);
        settle(1100);
        wr(SEL_FORMAT, d, 1);
    endtask

    task automatic zeros(int n);
        @(negedge abclk);
        adata = 1'b0;
        repeat (n) @(posedge abclk);
        settle(6);
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] c;
        void'($urandom(32'h115e));
        repeat (6) @(posedge ref_clk);
        #2 srst = 1'b0;
        model_defaults();
        settle(6);
        note("registers", 0, exp_snap());
        note("output state", 1, 32'h2);
        // Right gain: commit clear is stored only
        for (int k = 0; k < 3; k++) begin
            c = (k == 0) ? GAIN_MUTE : (k == 1) ? GAIN_UNITY : 8'(k * 77);
            wr(SEL_RIGHT_GAIN, {1'b0, ~c}, 1);
            wr(SEL_RIGHT_GAIN, {1'b1, c}, 1);
            note("right level", 3, {24'h0, c});
        end
        note("left level", 2, {24'h0, lcode});
        fmt(9'h004);
        note("right level", 3, {24'h0, lcode});
        fmt(9'h000);
        // Soft mute ramps, never steps
        wr(SEL_PLAYBACK, 9'h121, 1);
        note("ramp gradual", 5, 32'h1);
        settle(600);
        note("left level", 2, 32'h0);
        note("right level", 3, 32'h0);
        wr(SEL_PLAYBACK, 9'h120, 1);
        settle(600);
        note("left level", 2, {24'h0, lcode});
        lcode = 8'($urandom);
        // Word length kept off the reserved code
        for (int r = 0; r < 16; r++) begin
            wr(SEL_PLAYBACK, {4'(r), 2'($urandom_range(0, 2)), 1'b0,
                2'($urandom)}, 1);
        end
        wr(SEL_PLAYBACK, 9'h124, 1);
        note("output state", 1, 32'h4);
        wr(SEL_PLAYBACK, 9'h120, 1);
        note("output state", 1, 32'h2);
        wr(2'b00, 9'(($urandom)), 1);
        wr(SEL_PLAYBACK, 9'(($urandom)), 0);
        // Rate fields kept off reserved codes
        for (int k = 0; k < 4; k++) begin
            awclk = k[0];
            fmt({1'b0, 2'(k % 3), 2'((k + 1) % 3),
                4'($urandom)});
            note("phase", 4, {31'h0, awclk ^ m_fc[FC_POL_BIT]});
        end
        fmt(9'h100);
        zeros(12);
        note("output state", 1, 32'h2);
        zeros(8);
        note("output state", 1, 32'h5);
        @(negedge abclk);
        adata = 1'b1;
        zeros(0);
        adata = 1'b1;
        repeat (3) @(posedge abclk);
        settle(6);
        note("output state", 1, 32'h2);
        fmt(9'h000);
        zeros(20);
        note("output state", 1, 32'h3);
        adata = 1'b1;
        // Reset pin forces midscale and drops writes
        reset_pin_n = 1'b0;
        model_defaults();
        settle(6);
        note("output state", 1, 32'h4);
        wr(SEL_PLAYBACK, 9'h1E2, 1);
        reset_pin_n = 1'b1;
        settle(10);
        note("registers", 0, exp_snap());
        note("output state", 1, 32'h2);
        settle(2);
        tally_and_finish();
    end
endmodule
`default_nettype wire
